// ==== rtl/instruction_word_decoder.sv ====
/*
   Instruction word decoder with APB register access.
   Software loads operand values, then writes the instruction word, which
   is decoded, predicated and executed one clock later.
   Assumes an APB master on clk; write-back port feeds a register file.
*/
// Our own choices: the placing of the registers and the APB interface to the registers.
// Overview of operation
// - Operation code comes from bits 31 to 26 of the word.
// - Four effect bits sit at 25 to 22 below the opcode.
// - Four predicate bits at 21 to 18 give the execute condition.
// - Bits 17 to 9 address the destination and result register.
// - Bits 8 to 0 are source address or nine-bit literal.
// - Effect bits: zero write, carry write, result write, immediate.
// - A flag changes only when its write bit is one, or when software writes the flags register over APB.
// - Result is written to destination only when result bit is one.
// - Predicate all-ones means always execute.
// - Execute or skip by predicate against the current flags.
// - Skipped instruction changes neither flags nor destination.
// - Signed add sets zero flag exactly when the 32-bit sum is zero.
// - Signed add carry flag shows signed overflow; wrapped sum kept.
`timescale 1ns/1ns
module instruction_word_decoder
   import instruction_word_decoder_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Decoded fields of the last issued word
   output decoded_fields_t  decoded,
   // Result write-back toward the register file
   output write_back_t      write_back,
   // Flags
   output logic             zero_flag,
   output logic             carry_flag
);

   // Bus state
   logic             pready_reg;
   logic             pready_next;
   logic [31:0]      prdata_reg;
   logic [31:0]      prdata_next;
   logic             pslverr_reg;
   logic             pslverr_next;

   // Software-visible state
   logic [31:0]      operation_code_field_reg;
   logic [31:0]      operation_code_field_next;
   logic [31:0]      target_register_field_operand_reg;
   logic [31:0]      target_register_field_operand_next;
   logic [31:0]      src_operand_reg;
   logic [31:0]      src_operand_next;
   logic [31:0]      result_reg;
   logic [31:0]      result_next;
   logic             zero_reg;
   logic             zero_next;
   logic             carry_reg;
   logic             carry_next;
   exec_status_t     status_reg;
   exec_status_t     status_next;
   logic             issue_reg;
   logic             issue_next;

   // Decode and write-back state
   decoded_fields_t  decoded_reg;
   decoded_fields_t  decoded_next;
   write_back_t      write_back_reg;
   write_back_t      write_back_next;

   // Execution helpers
   decoded_fields_t  fields;
   logic [31:0]      operand_b;
   logic [31:0]      sum;
   logic             overflow;
   logic             predicate_met;
   logic             is_add;
   logic             access;
   logic             setup;
   logic             mapped;

   assign setup  = psel && !penable;
   assign access = psel && penable && pready_reg;

   // Field extraction from the instruction word
   always_comb
   begin
      fields.operation_code_field  = operation_code_field_reg[OPCODE_MSB:OPCODE_LSB];
      fields.effect_flags_field    = operation_code_field_reg[EFFECT_MSB:EFFECT_LSB];
      fields.predicate_field       = operation_code_field_reg[PREDICATE_MSB:PREDICATE_LSB];
      fields.target_register_field = operation_code_field_reg[TARGET_MSB:TARGET_LSB];
      fields.operand_b_field       = operation_code_field_reg[OPERAND_B_MSB:OPERAND_B_LSB];
   end

   // Source is a zero-extended literal or the addressed register value
   always_comb
   begin
      if (fields.effect_flags_field[EFFECT_IMM_BIT])
      begin
         operand_b = {23'h000000, fields.operand_b_field};
      end
      else
      begin
         operand_b = src_operand_reg;
      end
   end

   // Predicate is a truth table indexed by {carry, zero}
   always_comb
   begin
      if (fields.predicate_field == PREDICATE_ALWAYS)
      begin
         predicate_met = 1'b1;
      end
      else
      begin
         predicate_met = fields.predicate_field[{carry_reg, zero_reg}];
      end
   end

   // Signed addition, wrapped to 32 bits
   always_comb
   begin
      sum      = 32'(target_register_field_operand_reg + operand_b);
      overflow = (target_register_field_operand_reg[31] == operand_b[31])
                 && (sum[31] != target_register_field_operand_reg[31]);
      is_add   = (fields.operation_code_field == SIGNED_ADD_OP);
   end

   // Register address decode
   always_comb
   begin
      case (paddr)
         OPERATION_CODE_FIELD_WORD_OFFSET,
         TARGET_REGISTER_FIELD_OPERAND_OFFSET,
         SRC_OPERAND_OFFSET,
         FLAGS_OFFSET,
         RESULT_OFFSET,
         STATUS_OFFSET: mapped = 1'b1;
         default:       mapped = 1'b0;
      endcase
   end

   // APB answer: ready one cycle after setup, read data captured at setup
   always_comb
   begin
      pready_next  = setup;
      pslverr_next = setup && !mapped;
      prdata_next  = prdata_reg;
      if (setup)
      begin
         case (paddr)
            OPERATION_CODE_FIELD_WORD_OFFSET:   prdata_next = operation_code_field_reg;
            TARGET_REGISTER_FIELD_OPERAND_OFFSET: prdata_next = target_register_field_operand_reg;
            SRC_OPERAND_OFFSET:  prdata_next = src_operand_reg;
            FLAGS_OFFSET:        prdata_next = {30'h00000000, carry_reg, zero_reg};
            RESULT_OFFSET:       prdata_next = result_reg;
            STATUS_OFFSET:       prdata_next = {28'h0000000, status_reg};
            default:             prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Instruction and operand writes land at the access edge
   always_comb
   begin
      operation_code_field_next        = operation_code_field_reg;
      target_register_field_operand_next = target_register_field_operand_reg;
      src_operand_next  = src_operand_reg;
      issue_next        = 1'b0;
      if (access && pwrite)
      begin
         case (paddr)
            OPERATION_CODE_FIELD_WORD_OFFSET:
            begin
               operation_code_field_next = pwdata;
               issue_next = 1'b1;
            end
            TARGET_REGISTER_FIELD_OPERAND_OFFSET: target_register_field_operand_next = pwdata;
            SRC_OPERAND_OFFSET:  src_operand_next  = pwdata;
            default:             ;
         endcase
      end
   end

   // Execution of the issued word one clock after its write
   always_comb
   begin
      zero_next             = zero_reg;
      carry_next            = carry_reg;
      result_next           = result_reg;
      status_next           = status_reg;
      decoded_next          = decoded_reg;
      write_back_next       = write_back_reg;
      write_back_next.valid = 1'b0;
      if (access && pwrite && (paddr == FLAGS_OFFSET))
      begin
         zero_next  = pwdata[FLAG_ZERO_BIT];
         carry_next = pwdata[FLAG_CARRY_BIT];
      end
      if (issue_reg)
      begin
         decoded_next = fields;
         status_next  = '0;
         if (!predicate_met)
         begin
            status_next.skipped = 1'b1;
         end
         else if (!is_add)
         begin
            status_next.executed   = 1'b1;
            status_next.unknown_op = 1'b1;
         end
         else
         begin
            status_next.executed = 1'b1;
            if (fields.effect_flags_field[EFFECT_ZERO_BIT])
            begin
               zero_next = (sum == 32'h0000_0000);
            end
            if (fields.effect_flags_field[EFFECT_CARRY_BIT])
            begin
               carry_next = overflow;
            end
            if (fields.effect_flags_field[EFFECT_RESULT_BIT])
            begin
               result_next           = sum;
               status_next.wrote     = 1'b1;
               write_back_next.valid = 1'b1;
               write_back_next.addr  = fields.target_register_field;
               write_back_next.data  = sum;
            end
         end
      end
   end

   // Bus answer registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Instruction word and operand registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         operation_code_field_reg        <= OPERATION_CODE_FIELD_WORD_RESET;
         target_register_field_operand_reg <= OPERAND_RESET;
         src_operand_reg  <= OPERAND_RESET;
         issue_reg        <= 1'b0;
      end
      else
      begin
         operation_code_field_reg        <= operation_code_field_next;
         target_register_field_operand_reg <= target_register_field_operand_next;
         src_operand_reg  <= src_operand_next;
         issue_reg        <= issue_next;
      end
   end

   // Execution outcome registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_reg     <= RESULT_RESET;
         zero_reg       <= FLAG_RESET;
         carry_reg      <= FLAG_RESET;
         status_reg     <= '0;
         decoded_reg    <= '0;
         write_back_reg <= '0;
      end
      else
      begin
         result_reg     <= result_next;
         zero_reg       <= zero_next;
         carry_reg      <= carry_next;
         status_reg     <= status_next;
         decoded_reg    <= decoded_next;
         write_back_reg <= write_back_next;
      end
   end

   assign pready     = pready_reg;
   assign prdata     = prdata_reg;
   assign pslverr    = pslverr_reg;
   assign decoded    = decoded_reg;
   assign write_back = write_back_reg;
   assign zero_flag  = zero_reg;
   assign carry_flag = carry_reg;

endmodule

// ==== rtl/instruction_word_decoder_pkg.sv ====
/*
   Constants, register map and carrier types of the instruction word decoder.
   Assumes a 32-bit APB master and one synchronous clock domain.
*/
package instruction_word_decoder_pkg;

   // Instruction word field positions
   localparam int OPCODE_MSB     = 31;
   localparam int OPCODE_LSB     = 26;
   localparam int EFFECT_MSB     = 25;
   localparam int EFFECT_LSB     = 22;
   localparam int PREDICATE_MSB  = 21;
   localparam int PREDICATE_LSB  = 18;
   localparam int TARGET_MSB     = 17;
   localparam int TARGET_LSB     = 9;
   localparam int OPERAND_B_MSB  = 8;
   localparam int OPERAND_B_LSB  = 0;

   // Bit positions inside the effect flags field
   localparam int EFFECT_ZERO_BIT   = 3;
   localparam int EFFECT_CARRY_BIT  = 2;
   localparam int EFFECT_RESULT_BIT = 1;
   localparam int EFFECT_IMM_BIT    = 0;

   // Opcode that selects signed addition (value is a plain default)
   localparam logic [5:0] SIGNED_ADD_OP = 6'h01;

   // Predicate encoding that always executes
   localparam logic [3:0] PREDICATE_ALWAYS = 4'hf;

   // Register byte offsets
   localparam logic [11:0] OPERATION_CODE_FIELD_WORD_OFFSET   = 12'h000;
   localparam logic [11:0] TARGET_REGISTER_FIELD_OPERAND_OFFSET = 12'h004;
   localparam logic [11:0] SRC_OPERAND_OFFSET  = 12'h008;
   localparam logic [11:0] FLAGS_OFFSET        = 12'h00c;
   localparam logic [11:0] RESULT_OFFSET       = 12'h010;
   localparam logic [11:0] STATUS_OFFSET       = 12'h014;

   // Flag register bit positions
   localparam int FLAG_ZERO_BIT  = 0;
   localparam int FLAG_CARRY_BIT = 1;

   // Status register bit positions
   localparam int STATUS_EXECUTED_BIT = 0;
   localparam int STATUS_SKIPPED_BIT  = 1;
   localparam int STATUS_WROTE_BIT    = 2;
   localparam int STATUS_UNKNOWN_BIT  = 3;

   // Reset values
   localparam logic [31:0] OPERATION_CODE_FIELD_WORD_RESET = 32'h0000_0000;
   localparam logic [31:0] OPERAND_RESET    = 32'h0000_0000;
   localparam logic [31:0] RESULT_RESET     = 32'h0000_0000;
   localparam logic        FLAG_RESET       = 1'b0;

   // Decoded view of one instruction word
   typedef struct packed {
      logic [5:0] operation_code_field;
      logic [3:0] effect_flags_field;
      logic [3:0] predicate_field;
      logic [8:0] target_register_field;
      logic [8:0] operand_b_field;
   } decoded_fields_t;

   // Outcome of the last issued instruction
   typedef struct packed {
      logic unknown_op;
      logic wrote;
      logic skipped;
      logic executed;
   } exec_status_t;

   // Result write-back toward the register file
   typedef struct packed {
      logic        valid;
      logic [8:0]  addr;
      logic [31:0] data;
   } write_back_t;

endpackage

// ==== verification/instruction_word_decoder_props.sv ====
/*
   Checker of the decoder ports: fields, predication, flag and add results.
   Assumes operands are loaded over APB before the word that uses them.
*/
`timescale 1ns/1ns
module instruction_word_decoder_props
   import instruction_word_decoder_pkg::*;
(
   // Clock and reset
   input wire logic            clk,
   input wire logic            rst_n,
   // APB
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic            pready,
   input wire logic [31:0]     prdata,
   input wire logic            pslverr,
   // Decoder outputs
   input wire decoded_fields_t decoded,
   input wire write_back_t     write_back,
   input wire logic            zero_flag,
   input wire logic            carry_flag
);
   logic        wr_any;
   logic        wr_operation_code_field;
   logic        exec_q;
   logic        pred_ok;
   logic        add_ok;
   logic [31:0] word_q;
   logic [31:0] dst_q;
   logic [31:0] src_q;
   logic [31:0] b_val;
   logic [31:0] sum;
   assign wr_any   = psel && penable && pready && pwrite;
   assign wr_operation_code_field = wr_any && paddr == OPERATION_CODE_FIELD_WORD_OFFSET;
   assign pred_ok  = word_q[18 + {carry_flag, zero_flag}];
   assign add_ok   = exec_q && pred_ok && word_q[31:26] == SIGNED_ADD_OP;
   assign b_val    = word_q[22] ? {23'h0, word_q[8:0]} : src_q;
   assign sum      = dst_q + b_val;
   // Shadow of the issued word and operands
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         exec_q <= 1'b0;
         word_q <= 32'h0;
         dst_q  <= 32'h0;
         src_q  <= 32'h0;
      end
      else
      begin
         exec_q <= wr_operation_code_field;
         word_q <= wr_operation_code_field ? pwdata : word_q;
         dst_q  <= (wr_any && paddr == TARGET_REGISTER_FIELD_OPERAND_OFFSET) ? pwdata : dst_q;
         src_q  <= (wr_any && paddr == SRC_OPERAND_OFFSET) ? pwdata : src_q;
      end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_opcode_field:
      assert property (wr_operation_code_field |-> ##2 decoded.operation_code_field == word_q[31:26])
      else $error("opcode field wrong");
   chk_effect_field:
      assert property (wr_operation_code_field |-> ##2 decoded.effect_flags_field == word_q[25:22])
      else $error("effect field wrong");
   chk_predicate_field:
      assert property (wr_operation_code_field |-> ##2 decoded.predicate_field == word_q[21:18])
      else $error("predicate field wrong");
   chk_register_fields:
      assert property (wr_operation_code_field |-> ##2 decoded.target_register_field == word_q[17:9]
                       && decoded.operand_b_field == word_q[8:0])
      else $error("register fields wrong");
   chk_skip_no_change:
      assert property (exec_q && !pred_ok |=> $stable(zero_flag) && $stable(carry_flag)
                       && !write_back.valid)
      else $error("skipped word changed state");
   chk_flag_write_gate:
      assert property (exec_q |=> (word_q[25] || $stable(zero_flag))
                       && (word_q[24] || $stable(carry_flag)))
      else $error("flag changed without write bit");
   chk_wb_cause:
      assert property (write_back.valid |-> $past(exec_q) && word_q[23])
      else $error("write-back without cause");
   chk_add_zero:
      assert property (add_ok && word_q[25] |=> zero_flag == (sum == 32'h0))
      else $error("zero flag wrong");
   chk_add_overflow:
      assert property (add_ok && word_q[24] |=> carry_flag == ((dst_q[31] == b_val[31])
                       && (sum[31] != dst_q[31])))
      else $error("carry flag wrong");
   chk_add_wrap:
      assert property (add_ok && word_q[23] |=> write_back.valid && write_back.data == sum
                       && write_back.addr == word_q[17:9])
      else $error("write-back data wrong");
endmodule

bind instruction_word_decoder instruction_word_decoder_props props_i (.*);

// ==== verification/instruction_word_decoder_tb_top.sv ====
/*
   Self-checking bench: APB master, add truth table, random predicated words.
   Assumes zero-wait APB slave and the register file model on write-back.
*/
`timescale 1ns/1ns
module instruction_word_decoder_tb_top
   import instruction_word_decoder_pkg::*;
;
   logic            clk = 0;
   logic            rst_n = 0;
   logic            psel = 0;
   logic            penable = 0;
   logic            pwrite = 0;
   logic [11:0]     paddr = 12'h0;
   logic [31:0]     pwdata = 32'h0;
   logic            pready, pslverr, zero_flag, carry_flag, rerr;
   logic [31:0]     prdata, rd;
   decoded_fields_t decoded;
   write_back_t     write_back;
   int              err_count = 0;
   int              compares = 0;
   int              cyc = 0;
   logic [31:0]     exp_result = 32'h0;
   logic [31:0]     tt_d [8] = '{32'hffff_ffff, 32'hffff_ffff, 32'h1, 32'h1,
                                 32'h7fff_fffe, 32'h7fff_fffe, 32'h8000_0001, 32'h8000_0001};
   logic [31:0]     tt_s [8] = '{32'h1, 32'h2, 32'hffff_ffff, 32'hffff_fffe,
                                 32'h1, 32'h2, 32'hffff_ffff, 32'hffff_fffe};

   instruction_word_decoder DUT (.*);
   register_file_model      rf (.*);

   initial forever #20 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd      = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Signed add: {overflow, zero, wrapped sum}
   function automatic logic [33:0] add_model(input logic [31:0] x, input logic [31:0] y);
      logic [31:0] s;
      s = x + y;
      return {(x[31] == y[31]) && (s[31] != x[31]), s == 32'h0, s};
   endfunction

   task automatic run_op(input logic [5:0] op, input logic [3:0] eff, input logic [3:0] pred,
                         input logic [31:0] dst, input logic [31:0] srcv, input logic [1:0] f0);
      logic [31:0] word;
      logic [33:0] m;
      logic        ex, add, wr, ez, ec;
      int          n;
      word = {op, eff, pred, 9'($urandom), 9'($urandom)};
      apb(1'b1, FLAGS_OFFSET, {30'h0, f0});
      apb(1'b1, TARGET_REGISTER_FIELD_OPERAND_OFFSET, dst);
      apb(1'b1, SRC_OPERAND_OFFSET, srcv);
      n = rf.wb_count;
      apb(1'b1, OPERATION_CODE_FIELD_WORD_OFFSET, word);
      repeat (3) @(posedge clk);
      ex  = pred[f0];
      add = ex && op == SIGNED_ADD_OP;
      wr  = add && eff[1];
      m   = add_model(dst, eff[0] ? {23'h0, word[8:0]} : srcv);
      check("decoded", decoded, word);
      ez  = (add && eff[3]) ? m[32] : f0[0];
      ec  = (add && eff[2]) ? m[33] : f0[1];
      if (wr)
         exp_result = m[31:0];
      check("zero pin", zero_flag, ez);
      check("carry pin", carry_flag, ec);
      apb(1'b0, FLAGS_OFFSET, 32'h0);
      check("zero flag", rd[0], ez);
      check("carry flag", rd[1], ec);
      check("write count", 32'(rf.wb_count - n), 32'(wr));
      if (wr)
         check("result", rf.mem[word[17:9]], m[31:0]);
      apb(1'b0, RESULT_OFFSET, 32'h0);
      check("result reg", rd, exp_result);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check("status", rd[3:0], {ex && op != SIGNED_ADD_OP, wr, !ex, ex});
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      void'($urandom(31));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b1, RESULT_OFFSET, 32'hffff_ffff);
      apb(1'b1, STATUS_OFFSET, 32'hffff_ffff);
      for (int a = 0; a < 6; a++)
      begin
         apb(1'b0, 12'(a * 4), 32'h0);
         check("reset value", rd, 32'h0);
      end
      apb(1'b1, 12'h020, 32'h1234_5678);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped err", rerr, 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 8; i++)
         run_op(SIGNED_ADD_OP, 4'b1110, PREDICATE_ALWAYS, tt_d[i], tt_s[i], 2'($urandom));
      $display("test add table done");
      for (int i = 0; i < 32; i++)
         run_op(($urandom % 2) ? SIGNED_ADD_OP : 6'($urandom), 4'($urandom), 4'(i),
                $urandom, $urandom, 2'($urandom));
      $display("test random words done");
      final_report();
   end
endmodule

// ==== verification/register_file_model.sv ====
/*
   Register file behind the decoder: stores each write-back pulse.
   Assumes write_back.valid is a one-cycle pulse on clk.
*/
`timescale 1ns/1ns
module register_file_model
   import instruction_word_decoder_pkg::*;
(
   // Clock
   input wire logic        clk,
   // Write-back from the decoder
   input wire write_back_t write_back
);
   logic [31:0] mem [512];
   int          wb_count = 0;
   always @(posedge clk)
      if (write_back.valid)
      begin
         mem[write_back.addr] <= write_back.data;
         wb_count <= wb_count + 1;
      end
endmodule
